// *** design/sltc_pkg.sv ***
package sltc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_TEST_ALIGN = 10'h02A;
    localparam logic [9:0] IDX_FRAME_OVR = 10'h02B;
    localparam logic [9:0] IDX_SCRAMBLE = 10'h02F;
    localparam logic [9:0] IDX_OCTETS = 10'h030;
    localparam logic [9:0] IDX_MF_LEN = 10'h031;
    localparam logic [9:0] IDX_SUBCLASS = 10'h034;
    localparam logic [9:0] IDX_SYNC_REQ = 10'h03A;
    localparam logic [9:0] IDX_LINK_TEST = 10'h03B;
    localparam logic [9:0] IDX_LMFC_INIT = 10'h03C;
    localparam logic [9:0] IDX_STATUS = 10'h03D;
    localparam logic [9:0] IDX_CHA_TUNE = 10'h122;
    localparam logic [9:0] IDX_CHA_DITH = 10'h134;
    localparam logic [9:0] IDX_CHD_TUNE = 10'h222;
    localparam logic [9:0] IDX_CHD_DITH = 10'h234;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_OCTETS = 8'h02;
    localparam logic [7:0] RST_MF_LEN = 8'h08;
    // Defaults when overrides are off, and the last multiframe count
    localparam logic [7:0] DEF_OCTETS = 8'h02;
    localparam logic [4:0] DEF_FRAMES = 5'h09;
    localparam logic [4:0] LMFC_LAST = 5'h1F;
    // Field positions in the control registers
    localparam int TT_HI = 7;
    localparam int TT_LO = 6;
    localparam int B_IDLE_SYNC = 5;
    localparam int B_CODE_SEL = 4;
    localparam int B_FLIP = 3;
    localparam int B_LANE_MARK = 2;
    localparam int B_FRAME_MARK = 1;
    localparam int B_ILA_SKIP = 0;
    localparam int B_K_OVR = 1;
    localparam int B_F_OVR = 0;
    localparam int B_SCR_ON = 7;
    localparam int SC_HI = 7;
    localparam int SC_LO = 5;
    localparam int B_SOFT_REQ = 7;
    localparam int B_REQ_SRC = 6;
    localparam int LT_HI = 7;
    localparam int LT_LO = 5;
    localparam int B_RPAT_FLIP = 4;
    localparam int B_PD2 = 2;
    localparam int B_PD1 = 1;
    localparam int B_PD0 = 0;
    localparam int B_LMFC_OVR = 7;
    localparam int LI_HI = 6;
    localparam int LI_LO = 2;
    localparam int RD_HI = 1;
    localparam int RD_LO = 0;
    localparam int B_DITH_HI = 5;
    localparam int B_DITH_LO = 3;
    // Field encodings
    localparam logic [1:0] TT_NORMAL = 2'h0;
    localparam logic [1:0] TT_CLOCK = 2'h1;
    localparam logic [1:0] TT_ENCODED = 2'h2;
    localparam logic [1:0] TT_PRBS = 2'h3;
    localparam logic [2:0] LT_NORMAL = 3'h0;
    localparam logic [2:0] LT_D215 = 3'h1;
    localparam logic [2:0] LT_K285 = 3'h2;
    localparam logic [2:0] LT_ILA_REP = 3'h3;
    localparam logic [2:0] LT_RPAT = 3'h4;
    localparam logic [2:0] SC_0 = 3'h0;
    localparam logic [2:0] SC_1 = 3'h1;
    localparam logic [2:0] SC_2 = 3'h2;
    // Characters
    localparam logic [7:0] CH_K285 = 8'hBC;
    localparam logic [7:0] CH_ALT2 = 8'h50;
    localparam logic [7:0] CH_K283 = 8'h7C;
    localparam logic [7:0] CH_K287 = 8'hFC;
    localparam logic [7:0] CH_K280 = 8'h1C;
    localparam logic [7:0] CH_D215 = 8'hB5;
    localparam logic [7:0] PAT_CLOCK = 8'hAA;
    localparam logic [7:0] PAT_ONES = 8'hFF;
    localparam logic [7:0] PAT_ZEROS = 8'h00;
    localparam logic [14:0] PRBS_SEED = 15'h7FFF;
    localparam logic [14:0] SCR_SEED = 15'h7FFF;
    localparam logic [3:0] RPAT_LEN = 4'hC;
    localparam logic [1:0] ILA_MFS = 2'h3;
    // Link sequencing states
    typedef enum logic [1:0] {
        ST_DATA = 2'b00,
        ST_CGS = 2'b01,
        ST_WAIT = 2'b10,
        ST_ILA = 2'b11
    } sltc_state_t;
endpackage

// *** design/sltc_top.sv ***
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module sltc_top (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [11:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK,
    input wire logic [11:0] SAMPLE,
    input wire logic SYSREF,
    input wire logic RESYNC_PIN_POS,
    input wire logic RESYNC_PIN_NEG,
    output logic [7:0] LANE_DATA,
    output logic LANE_K,
    output logic DISP_INVERT,
    output logic DIV_RESET,
    output logic [1:0] CHAN_A_HARMONIC_TUNE,
    output logic [1:0] CHAN_D_HARMONIC_TUNE,
    output logic CHAN_A_DITHER_OFF,
    output logic CHAN_D_DITHER_OFF
);
    // Configuration registers
    logic [7:0] test_align, frame_ovr, scr_ctrl, octets_cfg, mf_len, subclass_cfg;
    logic [7:0] sync_ctrl, link_test, lmfc_init, cha_tune, cha_dith, chd_tune, chd_dith;
    // Link state
    sltc_pkg::sltc_state_t state, next_state;
    logic [7:0] oct_idx;
    logic [4:0] frame_idx, lmfc;
    logic [1:0] delay_cnt, ila_cnt;
    logic [3:0] rpat_idx;
    logic [14:0] prbs, scr;
    logic [15:0] word;
    logic sysref_d, req_d, pd1_d, armed;

    // Bus decode; registers sit at four times their index
    wire [9:0] idx = WB_ADR[11:2];
    wire bus_req = WB_CYC && WB_STB && !WB_ACK;
    wire wr = bus_req && WB_WE && WB_SEL[0];
    wire [7:0] wd = WB_DAT_I[7:0];
    wire [7:0] status = {4'h0, 1'b0, lmfc[0], state};
    logic [7:0] rd_mux;
    always_comb begin
        if (idx == sltc_pkg::IDX_TEST_ALIGN) rd_mux = test_align;
        else if (idx == sltc_pkg::IDX_FRAME_OVR) rd_mux = frame_ovr;
        else if (idx == sltc_pkg::IDX_SCRAMBLE) rd_mux = scr_ctrl;
        else if (idx == sltc_pkg::IDX_OCTETS) rd_mux = octets_cfg;
        else if (idx == sltc_pkg::IDX_MF_LEN) rd_mux = mf_len;
        else if (idx == sltc_pkg::IDX_SUBCLASS) rd_mux = subclass_cfg;
        else if (idx == sltc_pkg::IDX_SYNC_REQ) rd_mux = sync_ctrl;
        else if (idx == sltc_pkg::IDX_LINK_TEST) rd_mux = link_test;
        else if (idx == sltc_pkg::IDX_LMFC_INIT) rd_mux = lmfc_init;
        else if (idx == sltc_pkg::IDX_STATUS) rd_mux = {status[7:2], state};
        else if (idx == sltc_pkg::IDX_CHA_TUNE) rd_mux = cha_tune;
        else if (idx == sltc_pkg::IDX_CHA_DITH) rd_mux = cha_dith;
        else if (idx == sltc_pkg::IDX_CHD_TUNE) rd_mux = chd_tune;
        else if (idx == sltc_pkg::IDX_CHD_DITH) rd_mux = chd_dith;
        else rd_mux = 8'h00; // Unmapped reads as zero, still acked
    end

    // Ack one cycle after the request; write lands on that same edge
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            WB_ACK <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else if (CE) begin
            WB_ACK <= bus_req;
            WB_DAT_O <= {24'h000000, rd_mux};
        end
    end

    // Register file; values persist until rewritten or reset
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            test_align <= sltc_pkg::RST_ZERO;
            frame_ovr <= sltc_pkg::RST_ZERO;
            scr_ctrl <= sltc_pkg::RST_ZERO;
            octets_cfg <= sltc_pkg::RST_OCTETS;
            mf_len <= sltc_pkg::RST_MF_LEN;
            subclass_cfg <= sltc_pkg::RST_ZERO;
            sync_ctrl <= sltc_pkg::RST_ZERO;
            link_test <= sltc_pkg::RST_ZERO;
            lmfc_init <= sltc_pkg::RST_ZERO;
            cha_tune <= sltc_pkg::RST_ZERO;
            cha_dith <= sltc_pkg::RST_ZERO;
            chd_tune <= sltc_pkg::RST_ZERO;
            chd_dith <= sltc_pkg::RST_ZERO;
        end else if (CE && wr) begin
            if (idx == sltc_pkg::IDX_TEST_ALIGN) test_align <= wd;
            else if (idx == sltc_pkg::IDX_FRAME_OVR) frame_ovr <= wd;
            else if (idx == sltc_pkg::IDX_SCRAMBLE) scr_ctrl <= wd;
            else if (idx == sltc_pkg::IDX_OCTETS) octets_cfg <= wd;
            else if (idx == sltc_pkg::IDX_MF_LEN) mf_len <= {3'h0, wd[4:0]};
            else if (idx == sltc_pkg::IDX_SUBCLASS) subclass_cfg <= wd;
            else if (idx == sltc_pkg::IDX_SYNC_REQ) sync_ctrl <= wd;
            else if (idx == sltc_pkg::IDX_LINK_TEST) link_test <= wd;
            else if (idx == sltc_pkg::IDX_LMFC_INIT) lmfc_init <= wd;
            else if (idx == sltc_pkg::IDX_CHA_TUNE) cha_tune <= wd;
            else if (idx == sltc_pkg::IDX_CHA_DITH) cha_dith <= wd;
            else if (idx == sltc_pkg::IDX_CHD_TUNE) chd_tune <= wd;
            else if (idx == sltc_pkg::IDX_CHD_DITH) chd_dith <= wd;
        end
    end

    // Field extraction
    wire [1:0] tt_sel = test_align[sltc_pkg::TT_HI:sltc_pkg::TT_LO];
    wire [2:0] lt_sel = link_test[sltc_pkg::LT_HI:sltc_pkg::LT_LO];
    wire [2:0] subclass = subclass_cfg[sltc_pkg::SC_HI:sltc_pkg::SC_LO];
    wire [4:0] k_field = mf_len[4:0];
    // Zero sizes are clamped to one so the counters cannot run away
    wire [7:0] f_raw = frame_ovr[sltc_pkg::B_F_OVR] ? octets_cfg : sltc_pkg::DEF_OCTETS;
    wire [4:0] k_raw = frame_ovr[sltc_pkg::B_K_OVR] ? k_field : sltc_pkg::DEF_FRAMES;
    wire [7:0] f_eff = (f_raw == 8'h00) ? 8'h01 : f_raw;
    wire [4:0] k_eff = (k_raw == 5'h00) ? 5'h01 : k_raw;
    wire end_frame = (oct_idx == f_eff - 8'h01);
    wire end_mf = end_frame && (frame_idx == k_eff - 5'h01);

    // Sync request: active-low differential pair or software bit
    wire pin_req = !RESYNC_PIN_POS && RESYNC_PIN_NEG;
    wire sync_req = sync_ctrl[sltc_pkg::B_REQ_SRC] ?
        sync_ctrl[sltc_pkg::B_SOFT_REQ] : pin_req;

    // Pulse source depends on subclass: SYSREF for 1, sync edge for 2
    wire sysref_edge = SYSREF && !sysref_d;
    wire req_edge = sync_req && !req_d;
    wire pulse = (subclass == sltc_pkg::SC_2) ? req_edge : sysref_edge;
    wire pd0 = link_test[sltc_pkg::B_PD0];
    wire pd1_rise = link_test[sltc_pkg::B_PD1] && !pd1_d;
    wire pass_pulse = pd0 ? (pulse && armed) : (pulse && !link_test[sltc_pkg::B_PD2]);

    // Release timing: subclass 0 leaves at the next frame end, others wait for counter end
    wire lmfc_done = (lmfc == sltc_pkg::LMFC_LAST);
    wire cgs_exit = !sync_req && ((subclass == sltc_pkg::SC_0) || lmfc_done);
    wire [1:0] rel_delay = lmfc_init[sltc_pkg::RD_HI:sltc_pkg::RD_LO];

    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            sltc_pkg::ST_CGS: begin
                if (cgs_exit && end_frame) begin
                    if (test_align[sltc_pkg::B_ILA_SKIP]) next_state = sltc_pkg::ST_DATA;
                    else next_state = sltc_pkg::ST_WAIT;
                end
            end
            sltc_pkg::ST_WAIT: begin
                if (end_mf && delay_cnt == rel_delay) next_state = sltc_pkg::ST_ILA;
            end
            sltc_pkg::ST_ILA: begin
                if (end_mf && ila_cnt == sltc_pkg::ILA_MFS) next_state = sltc_pkg::ST_DATA;
            end
            default: begin
                next_state = sltc_pkg::ST_DATA;
            end
        endcase
        if (sync_req) next_state = sltc_pkg::ST_CGS;
    end

    // Converter word, bit order optionally reversed before packing
    logic [11:0] smp;
    always_comb begin
        smp = SAMPLE;
        for (int i = 0; i < 12; i++) begin
            if (test_align[sltc_pkg::B_FLIP]) smp[i] = SAMPLE[11 - i];
        end
    end

    // Self-synchronous scrambler, one octet per step, MSB first
    function automatic logic [22:0] scramble(input logic [14:0] st, input logic [7:0] d);
        logic [14:0] s;
        logic [7:0] o;
        s = st;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = d[i] ^ s[14] ^ s[13];
            s = {s[13:0], o[i]};
        end
        return {s, o};
    endfunction

    // PRBS15 generator, eight steps per octet
    function automatic logic [22:0] prbs_step(input logic [14:0] st);
        logic [14:0] s;
        logic [7:0] o;
        s = st;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = s[14] ^ s[13];
            s = {s[13:0], o[i]};
        end
        return {s, o};
    endfunction

    // Fixed 12-octet jitter pattern
    function automatic logic [7:0] rpat(input logic [3:0] i);
        case (i)
            4'h0: rpat = 8'hBE;
            4'h1: rpat = 8'hD7;
            4'h2: rpat = 8'h23;
            4'h3: rpat = 8'h47;
            4'h4: rpat = 8'h6B;
            4'h5: rpat = 8'h8F;
            4'h6: rpat = 8'hB3;
            4'h7: rpat = 8'h14;
            4'h8: rpat = 8'h5E;
            4'h9: rpat = 8'hFB;
            4'hA: rpat = 8'h35;
            default: rpat = 8'h59;
        endcase
    endfunction

    wire [15:0] next_word = (oct_idx == 8'h00) ? {smp, 4'h0} : word;
    wire [7:0] payload = (oct_idx == 8'h00) ? next_word[15:8] :
        (oct_idx == 8'h01) ? word[7:0] : 8'h00;
    wire [22:0] scr_res = scramble(scr, payload);
    wire [22:0] prbs_res = prbs_step(prbs);
    wire scr_on = scr_ctrl[sltc_pkg::B_SCR_ON];
    // Alignment markers ride on the first and last octet of each multiframe
    wire ila_first = (frame_idx == 5'h00) && (oct_idx == 8'h00);
    wire [7:0] ila_oct = ila_first ? sltc_pkg::CH_K280 :
        end_mf ? sltc_pkg::CH_K283 : oct_idx;

    // Octet selection; link tests override everything, then sequencing
    logic [7:0] next_data;
    logic next_k;
    logic use_scr;
    always_comb begin
        next_data = scr_on ? scr_res[7:0] : payload;
        next_k = 1'b0;
        use_scr = scr_on;
        if (lt_sel == sltc_pkg::LT_D215) begin
            next_data = sltc_pkg::CH_D215;
            use_scr = 1'b0;
        end else if (lt_sel == sltc_pkg::LT_K285) begin
            next_data = sltc_pkg::CH_K285;
            next_k = 1'b1;
            use_scr = 1'b0;
        end else if (lt_sel == sltc_pkg::LT_ILA_REP) begin
            next_data = (frame_idx == 5'h00) ? sltc_pkg::CH_K285 : ila_oct;
            next_k = (frame_idx == 5'h00) || ila_first || end_mf;
            use_scr = 1'b0;
        end else if (lt_sel == sltc_pkg::LT_RPAT) begin
            next_data = rpat(rpat_idx);
            use_scr = 1'b0;
        end else if (state == sltc_pkg::ST_CGS || state == sltc_pkg::ST_WAIT) begin
            // Second octet of the pair depends on code select
            next_k = !oct_idx[0] || !test_align[sltc_pkg::B_CODE_SEL];
            next_data = next_k ? sltc_pkg::CH_K285 : sltc_pkg::CH_ALT2;
            use_scr = 1'b0;
        end else if (state == sltc_pkg::ST_ILA) begin
            next_data = ila_oct;
            next_k = ila_first || end_mf;
            use_scr = 1'b0;
        end else if (test_align[sltc_pkg::B_IDLE_SYNC]) begin
            next_data = {frame_idx[3:0], oct_idx[3:0]};
            use_scr = 1'b0;
        end else if (tt_sel != sltc_pkg::TT_NORMAL) begin
            use_scr = 1'b0;
            if (tt_sel == sltc_pkg::TT_CLOCK) next_data = sltc_pkg::PAT_CLOCK;
            else if (tt_sel == sltc_pkg::TT_ENCODED)
                next_data = oct_idx[0] ? sltc_pkg::PAT_ZEROS : sltc_pkg::PAT_ONES;
            else next_data = prbs_res[7:0];
        end else if (end_mf && test_align[sltc_pkg::B_LANE_MARK]) begin
            next_data = sltc_pkg::CH_K283;
            next_k = 1'b1;
        end else if (end_frame && test_align[sltc_pkg::B_FRAME_MARK]) begin
            next_data = sltc_pkg::CH_K287;
            next_k = 1'b1;
        end
    end

    // Counters and lane output
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state <= sltc_pkg::ST_CGS;
            oct_idx <= 8'h00;
            frame_idx <= 5'h00;
            lmfc <= 5'h00;
            delay_cnt <= 2'h0;
            ila_cnt <= 2'h0;
            rpat_idx <= 4'h0;
            prbs <= sltc_pkg::PRBS_SEED;
            scr <= sltc_pkg::SCR_SEED;
            word <= 16'h0000;
            LANE_DATA <= 8'h00;
            LANE_K <= 1'b0;
        end else if (CE) begin
            state <= next_state;
            word <= next_word;
            oct_idx <= end_frame ? 8'h00 : oct_idx + 8'h01;
            if (end_mf) frame_idx <= 5'h00;
            else if (end_frame) frame_idx <= frame_idx + 5'h01;
            // Multiframe counter restarts on SYSREF, else advances per frame
            if (sysref_edge) begin
                lmfc <= lmfc_init[sltc_pkg::B_LMFC_OVR] ?
                    lmfc_init[sltc_pkg::LI_HI:sltc_pkg::LI_LO] : 5'h00;
            end else if (end_frame) begin
                lmfc <= lmfc + 5'h01;
            end
            if (state != sltc_pkg::ST_WAIT) delay_cnt <= 2'h0;
            else if (end_mf) delay_cnt <= delay_cnt + 2'h1;
            if (state != sltc_pkg::ST_ILA) ila_cnt <= 2'h0;
            else if (end_mf) ila_cnt <= ila_cnt + 2'h1;
            rpat_idx <= (rpat_idx == sltc_pkg::RPAT_LEN - 4'h1) ? 4'h0 : rpat_idx + 4'h1;
            prbs <= prbs_res[22:8];
            if (use_scr) scr <= scr_res[22:8];
            LANE_DATA <= next_data;
            LANE_K <= next_k;
        end
    end

    // Pulse filter and side outputs
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sysref_d <= 1'b0;
            req_d <= 1'b0;
            pd1_d <= 1'b0;
            armed <= 1'b0;
            DIV_RESET <= 1'b0;
            DISP_INVERT <= 1'b0;
            CHAN_A_HARMONIC_TUNE <= 2'h0;
            CHAN_D_HARMONIC_TUNE <= 2'h0;
            CHAN_A_DITHER_OFF <= 1'b0;
            CHAN_D_DITHER_OFF <= 1'b0;
        end else if (CE) begin
            sysref_d <= SYSREF;
            req_d <= sync_req;
            pd1_d <= link_test[sltc_pkg::B_PD1];
            // Arming edge wins over a consumed pulse in the same cycle
            if (pd1_rise) armed <= 1'b1;
            else if (pulse) armed <= 1'b0;
            DIV_RESET <= pass_pulse;
            DISP_INVERT <= link_test[sltc_pkg::B_RPAT_FLIP] && (lt_sel == sltc_pkg::LT_RPAT);
            CHAN_A_HARMONIC_TUNE <= cha_tune[1:0];
            CHAN_D_HARMONIC_TUNE <= chd_tune[1:0];
            CHAN_A_DITHER_OFF <= cha_dith[sltc_pkg::B_DITH_HI] && cha_dith[sltc_pkg::B_DITH_LO];
            CHAN_D_DITHER_OFF <= chd_dith[sltc_pkg::B_DITH_HI] && chd_dith[sltc_pkg::B_DITH_LO];
        end
    end
endmodule
`default_nettype wire

// *** tb/sltc_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sltc_asserts (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [11:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK,
    input wire logic [7:0] LANE_DATA,
    input wire logic LANE_K,
    input wire logic DISP_INVERT,
    input wire logic DIV_RESET
);
    // Shadow of the link test register, taken on the same edge as the design's copy
    logic [7:0] lt;
    wire take = CE && WB_CYC && WB_STB && !WB_ACK;
    wire lt_wr = take && WB_WE && WB_SEL[0] && WB_ADR[11:2] == sltc_pkg::IDX_LINK_TEST;
    always_ff @(posedge CLK_SYS) begin
        if (RST) lt <= 8'h00;
        else if (lt_wr) lt <= WB_DAT_I[7:0];
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Bus handshake; checks wait one edge after a shadow change so the output can follow
    a_ack_follows_req: assert property (take |=> WB_ACK) else $error("request not acked");
    a_ack_one_cycle: assert property (WB_ACK && CE |=> !WB_ACK) else $error("ack too long");
    a_ack_has_cause: assert property ($rose(WB_ACK) |-> $past(WB_CYC && WB_STB))
        else $error("ack without request");
    a_read_upper_zero: assert property (WB_ACK |-> WB_DAT_O[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_reset_quiet: assert property (disable iff (1'b0) RST && CE |=> !WB_ACK && !DIV_RESET
        && LANE_DATA == 8'h00) else $error("outputs live in reset");
    a_disp_follow: assert property ($past(CE) && $past(lt) == lt |->
        DISP_INVERT == (lt[4] && lt[7:5] == sltc_pkg::LT_RPAT)) else $error("disparity flag");
    a_k285_test: assert property (lt[7:5] == sltc_pkg::LT_K285 && $past(lt[7:5]) == sltc_pkg::LT_K285
        |-> LANE_K && LANE_DATA == sltc_pkg::CH_K285) else $error("K28.5 test octet");
    a_d215_test: assert property (lt[7:5] == sltc_pkg::LT_D215 && $past(lt[7:5]) == sltc_pkg::LT_D215
        |-> !LANE_K && LANE_DATA == sltc_pkg::CH_D215) else $error("D21.5 test octet");
    a_div_pulse: assert property (DIV_RESET && CE |=> !DIV_RESET) else $error("divider pulse long");
    a_div_blocked: assert property (lt[2:0] == 3'h4 && $past(lt[2:0]) == 3'h4 |-> !DIV_RESET)
        else $error("divider reset not blocked");
endmodule
bind sltc_top sltc_asserts chk_u (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .WB_CYC(WB_CYC),
    .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .LANE_DATA(LANE_DATA), .LANE_K(LANE_K),
    .DISP_INVERT(DISP_INVERT), .DIV_RESET(DIV_RESET));
`default_nettype wire

// *** tb/sltc_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sltc_rx_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic want_sync,
    output logic resync_pin_pos,
    output logic resync_pin_neg
);
    // Receiver asks for resync on the pair: active when pos low and neg high
    always_ff @(posedge clk) begin
        resync_pin_pos <= !(want_sync || rst);
        resync_pin_neg <= want_sync || rst;
    end
endmodule
`default_nettype wire

// *** tb/sltc_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sltc_tb_top;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sysref = 1'b0;
    logic want = 1'b1, ack, lk, dinv, divr, dao, ddo, rp, rn, seen;
    logic [3:0] sel = 4'hF;
    logic [11:0] adr = 12'h000, smp = 12'h000, rv;
    logic [31:0] wdat = 32'h0, dout, rdat;
    logic [7:0] ld;
    logic [1:0] hta, htd;
    integer seed = 32'he0bd, error_cnt = 0, compares = 0, i, n;
    int mdl[int];
    int regs[13] = '{'h2A, 'h2B, 'h2F, 'h30, 'h31, 'h34, 'h3A, 'h3B, 'h3C, 'h122, 'h134, 'h222, 'h234};
    always #25 clk = ~clk;
    sltc_top dut_u (.CLK_SYS(clk), .RST(rst), .CE(ce), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
        .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(wdat), .WB_DAT_O(dout), .WB_ACK(ack), .SAMPLE(smp),
        .SYSREF(sysref), .RESYNC_PIN_POS(rp), .RESYNC_PIN_NEG(rn), .LANE_DATA(ld), .LANE_K(lk),
        .DISP_INVERT(dinv), .DIV_RESET(divr), .CHAN_A_HARMONIC_TUNE(hta),
        .CHAN_D_HARMONIC_TUNE(htd), .CHAN_A_DITHER_OFF(dao), .CHAN_D_DITHER_OFF(ddo));
    sltc_rx_model rx_u (.clk(clk), .rst(rst), .want_sync(want), .resync_pin_pos(rp),
        .resync_pin_neg(rn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; only the watchdog ends the wait for ack
    task automatic bus(input int idx, input logic w, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {idx[9:0], 2'b00};
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dout;
        chk(dout & 32'hFFFFFF00, 32'h0);
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic wr(input int idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
        if (mdl.exists(idx)) mdl[idx] = d;
    endtask
    task automatic rdc(input int idx);
        bus(idx, 1'b0, 8'h00);
        chk(rdat, mdl.exists(idx) ? mdl[idx] : 0);
    endtask
    // Status polling; a stuck sequencer gives up after sixty reads
    task automatic poll(input int st, output int cnt);
        cnt = 0;
        do begin
            bus(sltc_pkg::IDX_STATUS, 1'b0, 8'h00);
            cnt++;
        end while (rdat[1:0] !== st && cnt < 60);
        chk(rdat[1:0], st);
    endtask
    task automatic outs();
        @(posedge clk);
        chk(hta, mdl['h122] & 3);
        chk(htd, mdl['h222] & 3);
        chk(dao, mdl['h134][5] & mdl['h134][3]);
        chk(ddo, mdl['h234][5] & mdl['h234][3]);
    endtask
    // Every octet must be one of three values; hits counts the third
    task automatic watch(input logic [7:0] a, b, c, output int hits);
        hits = 0;
        repeat (4) @(posedge clk);
        repeat (20) begin
            @(posedge clk);
            chk({31'h0, ld === a || ld === b || ld === c}, 32'h1);
            hits += (ld === c);
        end
    endtask
    // Each bit is the XOR of the bits 14 and 15 older, once descrambled
    task automatic lfsr(input logic [7:0] a, b);
        logic [31:0] h;
        logic [7:0] d;
        h = 32'h0;
        repeat (3) begin @(posedge clk); h = {h[23:0], ld}; end
        repeat (20) begin
            @(posedge clk);
            h = {h[23:0], ld};
            d = h[7:0] ^ h[22:15] ^ h[21:14];
            chk({31'h0, d === a || d === b}, 32'h1);
        end
    endtask
    task automatic pulse(input logic exp);
        @(posedge clk) sysref <= 1'b1;
        seen = 1'b0;
        repeat (8) begin @(posedge clk); seen |= divr; end
        sysref <= 1'b0;
        chk(seen, exp);
    endtask
    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        foreach (regs[i]) mdl[regs[i]] = 0;
        mdl['h30] = 2;
        mdl['h31] = 8;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) rdc(regs[i]);
        wr('h3E, 8'h5A);
        rdc('h3E);
        for (i = 0; i < 13; i++) wr(regs[i], i == 4 ? 8'h08 + 8'($unsigned($random(seed)) % 24)
            : 8'($random(seed)));
        foreach (regs[i]) rdc(regs[i]);
        outs();
        wr('h122, 8'h03);
        wr('h134, 8'h28);
        wr('h222, 8'h03);
        wr('h234, 8'h20);
        outs();
        for (i = 0; i < 9; i++) wr(regs[i], i == 3 ? 8'h02 : i == 4 ? 8'h08 : 8'h00);
        // Receiver pins hold the link in code group sync
        watch(8'hBC, 8'hBC, 8'hBC, n);
        chk(n, 20);
        wr('h2A, 8'h10);
        watch(8'hBC, 8'h50, 8'h50, n);
        chk(n, 10);
        wr('h2A, 8'h01);
        wr('h3A, 8'hC0);
        bus(sltc_pkg::IDX_STATUS, 1'b0, 8'h00);
        chk(rdat[1:0], 1);
        wr('h3A, 8'h40);
        poll(0, n);
        // Alignment kept and delayed by three multiframes
        wr('h2A, 8'h00);
        wr('h3C, 8'h03);
        wr('h3A, 8'hC0);
        wr('h3A, 8'h40);
        poll(3, n);
        chk(n > 12, 1);
        poll(0, n);
        smp <= 12'($random(seed));
        wr('h2F, 8'h00);
        watch(smp[11:4], {smp[3:0], 4'h0}, 8'h00, n);
        wr('h2F, 8'h80);
        lfsr(smp[11:4], {smp[3:0], 4'h0});
        wr('h2F, 8'h00);
        rv = {<<{smp}};
        wr('h2A, 8'h09);
        watch(rv[11:4], {rv[3:0], 4'h0}, 8'h00, n);
        wr('h2A, 8'h41);
        watch(8'hAA, 8'hAA, 8'hAA, n);
        wr('h2A, 8'h81);
        watch(8'hFF, 8'h00, 8'h00, n);
        wr('h2A, 8'hC1);
        lfsr(8'h00, 8'h00);
        // Idle pattern walks octet then frame index
        wr('h2A, 8'h21);
        @(posedge clk) n = ld;
        repeat (20) begin
            @(posedge clk);
            n = n[0] ? (n[7:4] == 8 ? 0 : n + 15) : n + 1;
            chk(ld, n);
        end
        // Clock enable low must freeze the lane
        ce <= 1'b0;
        @(posedge clk) n = ld;
        repeat (5) @(posedge clk);
        chk(ld, n);
        ce <= 1'b1;
        wr('h2A, 8'h03);
        watch(smp[11:4], {smp[3:0], 4'h0}, 8'hFC, n);
        chk(n > 0, 1);
        wr('h2A, 8'h05);
        watch(smp[11:4], {smp[3:0], 4'h0}, 8'h7C, n);
        chk(n > 0, 1);
        wr('h3B, 8'h20);
        watch(8'hB5, 8'hB5, 8'hB5, n);
        wr('h3B, 8'h80);
        repeat (2) @(posedge clk);
        chk(dinv, 0);
        for (i = 1; i < 5; i++) begin
            wr('h3B, 8'(i << 5) | 8'h10);
            repeat (2) @(posedge clk);
            chk(dinv, i == 4);
        end
        wr('h34, 8'h20);
        wr('h3B, 8'h00);
        pulse(1'b1);
        wr('h3B, 8'h04);
        pulse(1'b0);
        wr('h3B, 8'h01);
        wr('h3B, 8'h03);
        pulse(1'b1);
        pulse(1'b0);
        test_done();
    end
endmodule
`default_nettype wire
